// ### tcs_sequencer.sv
// tape control micro sequencer with wishbone register access
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "tcs_params.svh"

module tcs_sequencer #(
   parameter int CS_DEPTH = 8192
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // attachment interface
   output logic byte_offer_strobe_o,
   output logic [8:0] attach_bus_in_o,
   input wire logic byte_accept_strobe_i,
   input wire logic [8:0] attach_bus_out_i,
   // tape unit
   input wire logic [8:0] tape_byte_i,
   input wire logic [8:0] read_back_i,
   output logic [7:0] unit_write_bus_o,
   // external test conditions 0-15
   input wire logic [15:0] cond_i
);

   tcs_pkg::tcs_state_s st;
   tcs_pkg::tcs_state_s next_st;

   logic [15:0] cstore [0:CS_DEPTH-1];
   logic [8:0] local_reg [0:31];

   logic cs_we;
   logic lsr_we;
   logic [4:0] lsr_wa;
   logic [7:0] lsr_wd;

   // ***************************************************
   // helpers
   // ***************************************************
   // odd parity bit for a byte
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~^b;
   endfunction : odd_par

   function automatic logic par_ok(input tcs_pkg::tcs_byte_t b);
      par_ok = ^b;
   endfunction : par_ok

   function automatic logic [3:0] ones(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, b[i]};
      end
      ones = n;
   endfunction : ones

   // ***************************************************
   // fetch and decode
   // ***************************************************
   logic [15:0] word;
   logic [3:0] opc;
   logic [3:0] f1;
   logic [7:0] f2;
   logic [4:0] cnd_sel;
   logic [31:0] cnd;
   logic [8:0] b_reg;
   logic [8:0] a_bus;
   logic [8:0] alu;
   logic [4:0] ba;
   logic [4:0] xa;

   assign word = cstore[{st.test_sel, st.page, st.ic}];
   // ibm-style numbering: bit 0 is the msb of the word
   assign opc = word[15:12];
   assign f1 = word[11:8];
   assign f2 = word[7:0];
   assign cnd_sel = word[12:8];
   assign ba = {st.bank, f1};
   assign xa = {opc[0], f1};
   assign b_reg = local_reg[ba];
   assign a_bus = {1'b0, f2 | st.a_reg};

   always_comb begin
      cnd = 32'h0000_0000;
      cnd[15:0] = st.cnd_s2;
      cnd[`TCS_CND_ACCEPT] = st.accept_seen;
      cnd[`TCS_CND_OVERRUN] = st.sense[`TCS_SNS_VPE_BYTE][`TCS_SNS_OVR_BIT];
      cnd[`TCS_CND_EOD] = st.eod;
      cnd[`TCS_CND_COUNT_ZERO] = (st.count == 16'h0000);
      cnd[`TCS_CND_D_ZERO] = (st.d_reg == 8'h00);
      cnd[`TCS_CND_CARRY] = st.carry;
      cnd[`TCS_CND_OFFER] = st.offer;
      cnd[`TCS_CND_PET_SET] = (st.phase_error_tracks != 8'h00);
   end

   always_comb begin
      case (opc[2:1])
         `TCS_ALU_OR: alu = {1'b0, a_bus[7:0] | b_reg[7:0]};
         `TCS_ALU_ADD: alu = a_bus + {1'b0, b_reg[7:0]};
         `TCS_ALU_AND: alu = {1'b0, a_bus[7:0] & b_reg[7:0]};
         `TCS_ALU_XOR: alu = {1'b0, a_bus[7:0] ^ b_reg[7:0]};
         default: alu = 9'h000;
      endcase
   end

   // ***************************************************
   // next state
   // ***************************************************
   logic acc_edge;
   logic [7:0] rc;
   logic [7:0] fixed;
   logic [15:0] cnt_dec;
   logic wb_req;
   logic [31:0] wmask;

   assign acc_edge = st.acc_s2 & ~st.acc_s3;
   assign rc = st.rbuf[1][7:0];
   assign fixed = rc ^ st.phase_error_tracks;
   assign cnt_dec = st.count - 16'h0001;
   assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_comb begin
      next_st = st;
      cs_we = 1'b0;
      lsr_we = 1'b0;
      lsr_wa = ba;
      lsr_wd = 8'h00;
      // two-stage synchronisers on the attachment, tape and condition pins
      next_st.acc_s1 = byte_accept_strobe_i;
      next_st.acc_s2 = st.acc_s1;
      next_st.acc_s3 = st.acc_s2;
      next_st.abo_s1 = attach_bus_out_i;
      next_st.abo_s2 = st.abo_s1;
      next_st.tape_s1 = tape_byte_i;
      next_st.tape_s2 = st.tape_s1;
      next_st.rb_s1 = read_back_i;
      next_st.rb_s2 = st.rb_s1;
      next_st.cnd_s1 = cond_i;
      next_st.cnd_s2 = st.cnd_s1;

      if (st.run) begin
         next_st.ic = st.ic + 8'h01;
         case (opc[3:1])
            `TCS_OP_STORE_CONST: begin
               lsr_we = 1'b1;
               lsr_wa = xa;
               lsr_wd = f2;
               next_st.d_reg = f2;
            end
            `TCS_OP_COND_BRANCH: begin
               // page stays as it is
               if (cnd[cnd_sel]) begin
                  next_st.ic = f2;
               end
            end
            `TCS_OP_UNCOND_BRANCH: begin
               next_st.page = f1;
               next_st.ic = f2;
               next_st.test_sel = opc[0];
            end
            `TCS_OP_TRANSFER: begin
               case (f2)
                  `TCS_XFR_LSR_TO_IC: next_st.ic = local_reg[xa][7:0];
                  `TCS_XFR_LSR_TO_A: next_st.a_reg = local_reg[xa][7:0];
                  `TCS_XFR_BANK: next_st.bank = opc[0];
                  `TCS_XFR_LSR_TO_PET: next_st.phase_error_tracks = local_reg[xa][7:0];
                  `TCS_XFR_LSR_TO_UWB: next_st.uwb = local_reg[xa][7:0];
                  `TCS_XFR_D_TO_ABI: begin
                     next_st.attach_bus_in = {odd_par(st.d_reg), st.d_reg};
                     next_st.offer = 1'b1;
                  end
                  `TCS_XFR_READ_BYTE: begin
                     // shift buffer: new byte in, oldest byte out
                     next_st.rbuf = {st.rbuf[1], st.rbuf[0], st.tape_s2};
                     next_st.pbit = {st.pbit[1:0], par_ok(st.tape_s2)};
                     next_st.d_reg = rc;
                     if (!st.pbit[1]) begin
                        if (st.phase_error_tracks != 8'h00) begin
                           next_st.d_reg = fixed;
                        end else begin
                           next_st.sense[`TCS_SNS_VPE_BYTE]
                              [`TCS_SNS_VPE_BIT] = 1'b1;
                        end
                     end
                     if (rc == 8'hFF && st.rbuf[0][7:0] == 8'h00 &&
                         st.tape_s2[7:0] == 8'h00) begin
                        next_st.eod = 1'b1;
                        if (ones(st.phase_error_tracks) > 4'h1) begin
                           next_st.sense[`TCS_SNS_ENV_BYTE]
                              [`TCS_SNS_ENV_BIT] = 1'b1;
                           next_st.sense[`TCS_SNS_ENV_BYTE]
                              [`TCS_SNS_MTE_BIT] = 1'b1;
                        end
                     end
                  end
                  `TCS_XFR_WRITE_BYTE: begin
                     if (st.accept_seen) begin
                        lsr_we = 1'b1;
                        lsr_wa = xa;
                        lsr_wd = st.abo_hold[7:0];
                        next_st.accept_seen = 1'b0;
                        next_st.uwb = st.abo_hold[7:0];
                        next_st.count = cnt_dec;
                        next_st.offer = (cnt_dec != 16'h0000);
                     end else begin
                        next_st.sense[`TCS_SNS_VPE_BYTE]
                           [`TCS_SNS_OVR_BIT] = 1'b1;
                     end
                  end
                  `TCS_XFR_READBACK: begin
                     // flag only; the write keeps going
                     if (!par_ok(st.rb_s2)) begin
                        next_st.sense[`TCS_SNS_VPE_BYTE]
                           [`TCS_SNS_VPE_BIT] = 1'b1;
                     end
                  end
                  `TCS_XFR_SENSE_PAIR: begin
                     // odd byte of pair first
                     next_st.attach_bus_in = {odd_par(st.sense[{st.req_desc[1:0], 1'b1}]),
                        st.sense[{st.req_desc[1:0], 1'b1}]};
                     next_st.sns_even = {st.req_desc[1:0], 1'b0};
                     next_st.sns = tcs_pkg::TCS_SNS_ODD;
                     next_st.offer = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               next_st.d_reg = alu[7:0];
               next_st.carry = alu[8];
               if (!opc[0]) begin
                  lsr_we = 1'b1;
                  lsr_wd = alu[7:0];
               end
               // odd opcodes are the no-store forms
            end
         endcase
      end

      // accept handshake; set wins over a same-cycle consume
      if (acc_edge && st.offer) begin
         case (st.sns)
            tcs_pkg::TCS_SNS_ODD: begin
               next_st.attach_bus_in = {odd_par(st.sense[st.sns_even]),
                  st.sense[st.sns_even]};
               next_st.sns = tcs_pkg::TCS_SNS_EVEN;
               next_st.offer = 1'b1;
            end
            tcs_pkg::TCS_SNS_EVEN: begin
               next_st.sns = tcs_pkg::TCS_SNS_IDLE;
               next_st.offer = 1'b0;
            end
            default: begin
               next_st.offer = 1'b0;
               next_st.accept_seen = 1'b1;
               next_st.abo_hold = st.abo_s2;
            end
         endcase
      end

      // wishbone slave: ack one cycle after request, unmapped reads zero
      next_st.ack = wb_req;
      if (wb_req) begin
         next_st.dat = 32'h0000_0000;
         case (wb_adr_i)
            `TCS_OFS_CTRL: begin
               next_st.dat = {31'h0000_0000, st.run};
               if (wb_we_i && wb_sel_i[0]) begin
                  next_st.run = wb_dat_i[0];
               end
            end
            `TCS_OFS_CS_ADDR: begin
               next_st.dat = {19'h0_0000, st.cs_addr};
               if (wb_we_i) begin
                  next_st.cs_addr = wb_dat_i[12:0];
               end
            end
            `TCS_OFS_CS_DATA: begin
               if (wb_we_i) begin
                  cs_we = 1'b1;
                  next_st.cs_addr = st.cs_addr + 13'h0001;
               end
            end
            `TCS_OFS_PET: begin
               next_st.dat = {24'h00_0000, st.phase_error_tracks};
               if (wb_we_i && wb_sel_i[0]) begin
                  next_st.phase_error_tracks = wb_dat_i[7:0];
               end
            end
            `TCS_OFS_STATUS: begin
               next_st.dat = {6'h00, st.eod, st.bank, st.d_reg,
                  2'h0, st.run, st.test_sel, st.page, st.ic};
            end
            `TCS_OFS_SENSE_LO: next_st.dat = st.sense[3:0];
            `TCS_OFS_SENSE_HI: next_st.dat = st.sense[7:4];
            `TCS_OFS_COUNT: begin
               next_st.dat = {16'h0000, st.count};
               if (wb_we_i) begin
                  next_st.count = (st.count & ~wmask[15:0]) |
                     (wb_dat_i[15:0] & wmask[15:0]);
               end
            end
            `TCS_OFS_REQ_DESC: begin
               next_st.dat = {24'h00_0000, st.req_desc};
               if (wb_we_i && wb_sel_i[0]) begin
                  next_st.req_desc = wb_dat_i[7:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************************
   // registers and memories
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0; // counter and page to zero
      end else begin
         st <= next_st;
      end
   end

   // memories carry no reset; microcode must initialise what it reads
   always_ff @(posedge clk_i) begin
      if (cs_we) begin
         cstore[st.cs_addr] <= wb_dat_i[15:0];
      end
      if (lsr_we) begin
         local_reg[lsr_wa] <= {odd_par(lsr_wd), lsr_wd};
      end
   end

   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign byte_offer_strobe_o = st.offer;
   assign attach_bus_in_o = st.attach_bus_in;
   assign unit_write_bus_o = st.uwb;

endmodule : tcs_sequencer

// ### tcs_params.svh
// offsets, field positions and codes of the tape sequencer
// How it works
// - opcode bits 0-3, field1 4-7, field2 8-15
// - opcode map: store, branches, transfer, logicals
// - branch condition taken from word bits 3-7
// - true condition loads low counter, same page
// - false condition steps counter to next word
// - conditional branch never touches page register
// - unconditional branch loads page and low counter
// - opcode 7 fetches from test store card
// - a-bus operand is constant ored with a-reg
// - b-bus is local register in selected bank
// - alu result of opcode goes to d-reg
// - normal logicals write back to local register
// - no-store logicals only update d-reg and carry
// - bad read byte fixed by tracks, else parity
// - end of data: ones then two zeros
// - multi-track phase error at end of data sets envelope, multi-track
// - offer strobe answered by accept, else overrun
// - write byte decrements count, reoffers while nonzero
// - bad read-back parity flagged, write continues
// - sense pair by descriptor, odd byte first
// - even sense byte only after odd accepted
// - parity generated on every sense byte sent
// - counter is 256-word pages plus page register
// - 32 byte-wide local registers with parity, two banks
// - transfer code 05 bit 3 picks bank
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// ***************************************************
// wishbone register offsets (byte addresses)
// ***************************************************
`define TCS_OFS_CTRL 8'h00
`define TCS_OFS_CS_ADDR 8'h04
`define TCS_OFS_CS_DATA 8'h08
`define TCS_OFS_PET 8'h0C
`define TCS_OFS_STATUS 8'h10
`define TCS_OFS_SENSE_LO 8'h14
`define TCS_OFS_SENSE_HI 8'h18
`define TCS_OFS_COUNT 8'h1C
`define TCS_OFS_REQ_DESC 8'h20

// ***************************************************
// opcodes (word bits 0-3)
// ***************************************************
`define TCS_OP_STORE_CONST 3'h0
`define TCS_OP_COND_BRANCH 3'h1
`define TCS_OP_TRANSFER 3'h2
`define TCS_OP_UNCOND_BRANCH 3'h3
`define TCS_ALU_OR 2'h0
`define TCS_ALU_ADD 2'h1
`define TCS_ALU_AND 2'h2
`define TCS_ALU_XOR 2'h3

// ***************************************************
// transfer codes (field 2)
// ***************************************************
`define TCS_XFR_LSR_TO_IC 8'h01
`define TCS_XFR_LSR_TO_A 8'h02
`define TCS_XFR_BANK 8'h05
`define TCS_XFR_LSR_TO_PET 8'h06
`define TCS_XFR_D_TO_ABI 8'h10
`define TCS_XFR_READ_BYTE 8'h30
`define TCS_XFR_WRITE_BYTE 8'h41
`define TCS_XFR_READBACK 8'h42
`define TCS_XFR_LSR_TO_UWB 8'h43
`define TCS_XFR_SENSE_PAIR 8'h50

// ***************************************************
// sense bit positions and condition numbers
// ***************************************************
`define TCS_SNS_VPE_BYTE 3'h0
`define TCS_SNS_VPE_BIT 3'h2
`define TCS_SNS_OVR_BIT 3'h5
`define TCS_SNS_ENV_BYTE 3'h5
`define TCS_SNS_ENV_BIT 3'h0
`define TCS_SNS_MTE_BIT 3'h1
`define TCS_CND_ACCEPT 5'h10
`define TCS_CND_OVERRUN 5'h11
`define TCS_CND_EOD 5'h12
`define TCS_CND_COUNT_ZERO 5'h13
`define TCS_CND_D_ZERO 5'h14
`define TCS_CND_CARRY 5'h15
`define TCS_CND_OFFER 5'h16
`define TCS_CND_PET_SET 5'h17

`endif

// ### tcs_pkg.sv
// types of the tape control micro sequencer
package tcs_pkg;

   typedef enum logic [1:0] {
      TCS_SNS_IDLE,
      TCS_SNS_ODD,
      TCS_SNS_EVEN
   } tcs_sense_e;

   // one parity-carrying byte, parity in bit 8
   typedef logic [8:0] tcs_byte_t;

   typedef struct packed {
      logic run;
      logic [12:0] cs_addr;
      logic test_sel;
      logic [3:0] page;
      logic [7:0] ic;
      logic [7:0] a_reg;
      logic [7:0] d_reg;
      logic carry;
      logic bank;
      logic [7:0] phase_error_tracks;
      logic [15:0] count;
      logic [7:0] req_desc;
      logic offer;
      tcs_byte_t attach_bus_in;
      logic [7:0] uwb;
      tcs_byte_t abo_hold;
      logic accept_seen;
      logic eod;
      tcs_sense_e sns;
      logic [2:0] sns_even;
      logic [7:0][7:0] sense;
      tcs_byte_t [2:0] rbuf;
      logic [2:0] pbit;
      logic ack;
      logic [31:0] dat;
      logic acc_s1;
      logic acc_s2;
      logic acc_s3;
      tcs_byte_t abo_s1;
      tcs_byte_t abo_s2;
      tcs_byte_t tape_s1;
      tcs_byte_t tape_s2;
      tcs_byte_t rb_s1;
      tcs_byte_t rb_s2;
      logic [15:0] cnd_s1;
      logic [15:0] cnd_s2;
   } tcs_state_s;

endpackage : tcs_pkg

// ### tcs_checker.sv
// port assertions of the tape control micro sequencer
`timescale 1ns/1ps
module tcs_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // attachment
   input wire logic byte_offer_strobe_o,
   input wire logic [8:0] attach_bus_in_o,
   input wire logic byte_accept_strobe_i
);
   // ***************************************************
   // cycles since the accept pin rose, saturating
   // ***************************************************
   logic acc_q;
   logic [3:0] acc_age;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      acc_q <= byte_accept_strobe_i;
      if (rst_i) begin
         acc_age <= 4'hF;
      end else if (byte_accept_strobe_i && !acc_q) begin
         acc_age <= 4'h0;
      end else if (acc_age != 4'hF) begin
         acc_age <= acc_age + 4'h1;
      end
   end
   // ***************************************************
   // assertions
   // ***************************************************
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   ack_answer_a: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   unmapped_zero_a: assert property (wb_ack_o &&
      $past(!wb_we_i && wb_adr_i > 8'h20) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // sync latency is three cycles, six leaves margin
   offer_hold_a: assert property
      ($fell(byte_offer_strobe_o) |-> acc_age <= 4'h6)
      else $error("offer dropped without accept");
   abi_stable_a: assert property (byte_offer_strobe_o &&
      $past(byte_offer_strobe_o) && acc_age > 4'h7
      |-> $stable(attach_bus_in_o))
      else $error("offered byte changed before accept");
   abi_parity_a: assert property
      ($changed(attach_bus_in_o) |-> ^attach_bus_in_o)
      else $error("offered byte has even parity");
   reset_clear_a: assert property ($past(rst_i) |->
      !byte_offer_strobe_o && !wb_ack_o && attach_bus_in_o == 9'h000)
      else $error("outputs not clear after reset");
   offer_rise_c: cover property ($rose(byte_offer_strobe_o));
   write_ack_c: cover property (wb_ack_o && wb_we_i);
   sense_swap_c: cover property (byte_offer_strobe_o &&
      $past(byte_offer_strobe_o) && $changed(attach_bus_in_o));
endmodule : tcs_checker

bind tcs_sequencer tcs_checker i_tcs_checker (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .byte_offer_strobe_o(byte_offer_strobe_o),
   .attach_bus_in_o(attach_bus_in_o),
   .byte_accept_strobe_i(byte_accept_strobe_i)
);

// ### tcs_attach_model.sv
// host attachment model answering byte offers
`timescale 1ns/1ps
module tcs_attach_model #(
   parameter int DELAY = 4
) (
   // clock
   input wire logic clk_i,
   // offer side of the sequencer
   input wire logic offer_i,
   input wire logic [8:0] abi_i,
   // answer side
   output logic accept_o,
   output logic [8:0] abo_o
);
   logic [8:0] got[$];
   logic [8:0] seen;
   logic [7:0] v;
   int wait_n;
   initial begin
      accept_o = 1'b0;
      abo_o = 9'h155;
      wait_n = DELAY;
      forever begin
         @(posedge clk_i);
         if (offer_i === 1'b1) begin
            // alternate slow and prompt answers
            repeat (wait_n) @(posedge clk_i);
            wait_n = (wait_n == DELAY) ? 1 : DELAY;
            v = 8'hA5 ^ 8'(got.size());
            seen = abi_i;
            got.push_back(seen);
            accept_o <= 1'b1;
            abo_o <= {~^v, v};
            while (offer_i === 1'b1 && abi_i === seen) @(posedge clk_i);
            accept_o <= 1'b0;
            abo_o <= ~abo_o;
            // low long enough for the sync stages to see it
            repeat (3) @(posedge clk_i);
         end
      end
   end
endmodule : tcs_attach_model

// ### tb.sv
// self-checking testbench of the tape control micro sequencer
`timescale 1ns/1ps
`include "tcs_params.svh"
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic offer;
   logic [8:0] attach_bus_in;
   logic accept;
   logic [8:0] attach_bus_out;
   logic [8:0] read_back = 9'h100;
   logic [7:0] uwb;
   int failures = 0;
   int comparisons = 0;
   logic [31:0] st;
   logic [15:0] p[$];
   always #12.5 clk_i = ~clk_i;
   tcs_sequencer i_tcs_sequencer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .byte_offer_strobe_o(offer),
      .attach_bus_in_o(attach_bus_in),
      .byte_accept_strobe_i(accept),
      .attach_bus_out_i(attach_bus_out),
      .tape_byte_i(9'h100),
      .read_back_i(read_back),
      .unit_write_bus_o(uwb),
      .cond_i(16'h0000)
   );
   tcs_attach_model i_tcs_attach_model (
      .clk_i(clk_i),
      .offer_i(offer),
      .abi_i(attach_bus_in),
      .accept_o(accept),
      .abo_o(attach_bus_out)
   );
   // ***************************************************
   // access and compare tasks
   // ***************************************************
   task automatic stop_test();
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n == 20) failures++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask : rd
   // reset, load p behind a-reg clear, run until the status pc equals pc
   task automatic run(input logic [12:0] xa, input logic [15:0] xw,
         input logic [15:0] cnt, input logic [12:0] pc, input logic [7:0] d);
      int n = 0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`TCS_OFS_STATUS, st);
      check("reset pc", {19'h0, st[12:0]}, 32'h0);
      p.push_front(16'h4002);
      p.push_front(16'h0000);
      p.push_back(16'h6000 | 16'(p.size()));
      wr(`TCS_OFS_CS_ADDR, 32'h0);
      foreach (p[i]) wr(`TCS_OFS_CS_DATA, {16'h0, p[i]});
      if (xw != 16'h0) begin
         wr(`TCS_OFS_CS_ADDR, {19'h0, xa});
         wr(`TCS_OFS_CS_DATA, {16'h0, xw});
      end
      wr(`TCS_OFS_COUNT, {16'h0, cnt});
      i_tcs_attach_model.got.delete();
      wr(`TCS_OFS_CTRL, 32'h1);
      do begin
         rd(`TCS_OFS_STATUS, st);
         n++;
      end while (st[12:0] !== pc && n < 100);
      wr(`TCS_OFS_CTRL, 32'h0);
      rd(`TCS_OFS_STATUS, st);
      check("pc", {19'h0, st[12:0]}, {19'h0, pc});
      check("d reg", {24'h0, st[23:16]}, {24'h0, d});
   endtask : run
   // ***************************************************
   // tests
   // ***************************************************
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      p = '{16'h035A, 16'h8381, 16'h9324, 16'hB300};
      run(13'h0, 16'h0, 16'h0, 13'h006, 8'hDB);
      p = '{16'h03F0, 16'hA325, 16'hE3FF, 16'hC30F, 16'hF30F, 16'hD3F0,
         16'hB300};
      run(13'h0, 16'h0, 16'h0, 13'h009, 8'h0A);
      p = '{16'h0133, 16'h4102, 16'h0240, 16'h9204};
      run(13'h0, 16'h0, 16'h0, 13'h006, 8'h77);
      p = '{16'h13AA, 16'h0355, 16'h5005, 16'hA301, 16'h4005, 16'hB300,
         16'h5005, 16'hB300};
      run(13'h0, 16'h0, 16'h0, 13'h00A, 8'hAB);
      check("bank", {31'h0, st[24]}, 32'h1);
      // taken branch skips, untaken falls through, page kept
      p = '{16'h0500, 16'h3406, 16'h0511, 16'h6009, 16'h0522, 16'h3404,
         16'hB500};
      run(13'h0, 16'h0, 16'h0, 13'h009, 8'h22);
      check("page", {28'h0, st[11:8]}, 32'h0);
      // test card self loop on page one
      p = '{16'h7100};
      run(13'h1100, 16'h7100, 16'h0, 13'h1100, 8'h00);
      // offer of the d register, good read-back
      p = '{16'h0096, 16'h4010, 16'h4442, 16'h3007, 16'h6005};
      run(13'h0, 16'h0, 16'h0, 13'h007, 8'h96);
      check("abi", {23'h0, i_tcs_attach_model.got[0]}, 32'h196);
      rd(`TCS_OFS_SENSE_LO, st);
      check("sense", st, 32'h0);
      // two write bytes, bad read-back parity
      read_back = 9'h000;
      p = '{16'h4010, 16'h3005, 16'h6003, 16'h4441, 16'h4443, 16'h3009,
         16'h6007, 16'h4441, 16'h4443, 16'h4442, 16'hB400};
      run(13'h0, 16'h0, 16'h2, 13'h00D, 8'hA4);
      check("unit bus", {24'h0, uwb}, 32'hA4);
      check("offer", {31'h0, offer}, 32'h0);
      rd(`TCS_OFS_COUNT, st);
      check("count", st, 32'h0);
      rd(`TCS_OFS_SENSE_LO, st);
      check("sense", st, 32'h04);
      // overrun, then sense pair zero
      read_back = 9'h100;
      p = '{16'h4441, 16'h4050, 16'h0500, 16'h3605};
      run(13'h0, 16'h0, 16'h0, 13'h006, 8'h00);
      check("pairs", i_tcs_attach_model.got.size(), 32'h2);
      check("odd", {23'h0, i_tcs_attach_model.got[0]}, 32'h100);
      check("even", {23'h0, i_tcs_attach_model.got[1]}, 32'h020);
      rd(`TCS_OFS_SENSE_LO, st);
      check("overrun", st, 32'h20);
      // read-only sense, unmapped place, phase tracks
      wr(`TCS_OFS_SENSE_LO, 32'hFFFFFFFF);
      rd(`TCS_OFS_SENSE_LO, st);
      check("sense ro", st, 32'h20);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40, st);
      check("unmapped", st, 32'h0);
      wr(`TCS_OFS_PET, 32'hA5);
      rd(`TCS_OFS_PET, st);
      check("tracks", {24'h0, st[7:0]}, 32'hA5);
      stop_test();
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      failures++;
      stop_test();
   end
endmodule : tb
